// file: logic/bsc_cell.sv
module bsc_cell
    import bsc_pkg::*;
#(
    parameter bsc_kind_e KIND = BSC_KIND_BIDIR
) (
    input wire logic clk_i,          // System clock
    input wire logic arst_n_i,       // Async reset, active low
    input wire bsc_ctl_s ctl_i,      // Strobes and modes
    input wire logic scan_i,         // Serial in from the TDI side
    input wire logic func_out_i,     // Functional output value
    input wire logic func_oe_i,      // Functional output enable
    input wire logic pin_in_i,       // Pin level, asynchronous
    input wire logic grp_en_i,       // Group not disabled
    output logic scan_o,             // Shift stage
    output logic upd_o,              // Update latch
    output logic pin_out_o,          // Pin drive value
    output logic pin_oe_o            // Pin drive enable
);

    logic [2:0] sync;
    logic pin_val;
    logic has_out;

    assign has_out = (KIND == BSC_KIND_OUT) || (KIND == BSC_KIND_BIDIR);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync <= BSC_SYNC_RESET;
            pin_val <= BSC_CELL_RESET;
        end else begin
            sync <= {sync[1:0], pin_in_i};
            if (sync[1] == sync[2]) begin
                pin_val <= sync[2];
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scan_o <= BSC_CELL_RESET;
        end else if (ctl_i.capture) begin
            case (KIND)
                BSC_KIND_IN: scan_o <= pin_val;
                BSC_KIND_OUT: scan_o <= pin_oe_o ? pin_out_o : func_out_i;
                BSC_KIND_BIDIR: scan_o <= pin_val;
                default: scan_o <= BSC_CELL_RESET;
            endcase
        end else if (ctl_i.shift) begin
            scan_o <= scan_i;
        end
    end

    // Update latch holds the driven value between updates
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            upd_o <= BSC_CELL_RESET;
        end else if (ctl_i.update) begin
            upd_o <= scan_o;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_out_o <= 1'b0;
            pin_oe_o <= 1'b0;
        end else if (!has_out || ctl_i.float_all) begin
            pin_out_o <= 1'b0;
            pin_oe_o <= 1'b0;
        end else if (ctl_i.drive) begin
            pin_out_o <= upd_o;
            pin_oe_o <= grp_en_i;
        end else begin
            pin_out_o <= func_out_i;
            pin_oe_o <= func_oe_i;
        end
    end

endmodule

// file: logic/bsc_chain.sv
// Contract
// - A one-bit bypass stage links TDI to TDO when selected.
// - Boundary cells form one serial chain from TDI to TDO.
// - Cells capture, shift and update per instruction and TAP state.
// - Input-only cells sample the pin and shift, never drive.
// - Output cells sample, shift and drive the pin from scan data.
// - Bidirectional cells also capture the incoming pin and hold outputs.
// - Position 0 is address/data bit 0; 20 and 27 have no terminal.
// - Cells 19, 26 and 48 disable their output groups under extest and clamp.
// - Five-bit instruction: extest, sample, clamp and highz codes.
// - All-ones instruction selects the bypass stage.
module bsc_chain
    import bsc_pkg::*;
#(
    parameter int CHAIN_LEN = BSC_CHAIN_LEN
) (
    input wire logic clk_i,                     // System clock, 25 MHz
    input wire logic arst_n_i,                  // Async reset, active low
    input wire logic tck_i,                     // Test clock, asynchronous
    input wire logic tms_i,                     // Test mode select
    input wire logic tdi_i,                     // Test data in
    output logic tdo_o,                         // Test data out
    output logic tdo_oe_o,                      // TDO drive enable
    input wire logic [CHAIN_LEN-1:0] func_out_i, // Functional output values
    input wire logic [CHAIN_LEN-1:0] func_oe_i,  // Functional output enables
    input wire logic [CHAIN_LEN-1:0] pin_in_i,   // Pin levels, asynchronous
    output logic [CHAIN_LEN-1:0] pin_out_o,      // Pin drive values
    output logic [CHAIN_LEN-1:0] pin_oe_o        // Pin drive enables
);

    logic [2:0] sync [3];
    logic [2:0] jtag_val;
    logic tck_val;
    logic tck_rise;
    logic tck_fall;
    bsc_tap_e state;
    bsc_tap_e next_state;
    logic [BSC_IR_W-1:0] ir;
    logic [BSC_IR_W-1:0] ir_sr;
    logic bypass_bit;
    logic sel_bsr;
    bsc_ctl_s ctl;
    logic [CHAIN_LEN-1:0] scan;
    logic [CHAIN_LEN-1:0] upd;
    logic [CHAIN_LEN-1:0] grp_en;
    logic [2:0] jtag_pins;
    logic in_cap_dr;
    logic in_sh_dr;
    logic in_upd_dr;
    logic in_cap_ir;
    logic in_sh_ir;
    logic in_upd_ir;
    logic op_extest;
    logic op_sample;
    logic op_clamp;
    logic op_highz;
    logic dis_lo;
    logic dis_ctl;
    logic dis_hi;

    // Test pins in synchroniser order: clock, mode select, data
    assign jtag_pins = {tdi_i, tms_i, tck_i};

    // Pin synchronisers: value accepted when the last two stages agree
    for (genvar s = 0; s < 3; s++) begin : g_sync
        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                sync[s] <= BSC_SYNC_RESET;
                jtag_val[s] <= 1'b0;
            end else begin
                sync[s] <= {sync[s][1:0], jtag_pins[s]};
                if (sync[s][1] == sync[s][2]) begin
                    jtag_val[s] <= sync[s][2];
                end
            end
        end
    end

    // Edge pulses last one cycle: settled level differs from the accepted one
    assign tck_val = jtag_val[0];
    assign tck_rise = (sync[0][1] == sync[0][2]) && sync[0][2] && !tck_val;
    assign tck_fall = (sync[0][1] == sync[0][2]) && !sync[0][2] && tck_val;

    always_comb begin
        next_state = state;
        case (state)
            BSC_TLR: next_state = jtag_val[1] ? BSC_TLR : BSC_RTI;
            BSC_RTI: next_state = jtag_val[1] ? BSC_SEL_DR : BSC_RTI;
            BSC_SEL_DR: next_state = jtag_val[1] ? BSC_SEL_IR : BSC_CAP_DR;
            BSC_CAP_DR: next_state = jtag_val[1] ? BSC_EX1_DR : BSC_SH_DR;
            BSC_SH_DR: next_state = jtag_val[1] ? BSC_EX1_DR : BSC_SH_DR;
            BSC_EX1_DR: next_state = jtag_val[1] ? BSC_UPD_DR : BSC_PA_DR;
            BSC_PA_DR: next_state = jtag_val[1] ? BSC_EX2_DR : BSC_PA_DR;
            BSC_EX2_DR: next_state = jtag_val[1] ? BSC_UPD_DR : BSC_SH_DR;
            BSC_UPD_DR: next_state = jtag_val[1] ? BSC_SEL_DR : BSC_RTI;
            BSC_SEL_IR: next_state = jtag_val[1] ? BSC_TLR : BSC_CAP_IR;
            BSC_CAP_IR: next_state = jtag_val[1] ? BSC_EX1_IR : BSC_SH_IR;
            BSC_SH_IR: next_state = jtag_val[1] ? BSC_EX1_IR : BSC_SH_IR;
            BSC_EX1_IR: next_state = jtag_val[1] ? BSC_UPD_IR : BSC_PA_IR;
            BSC_PA_IR: next_state = jtag_val[1] ? BSC_EX2_IR : BSC_PA_IR;
            BSC_EX2_IR: next_state = jtag_val[1] ? BSC_UPD_IR : BSC_SH_IR;
            BSC_UPD_IR: next_state = jtag_val[1] ? BSC_SEL_DR : BSC_RTI;
            default: next_state = BSC_TLR;
        endcase
    end

    // The controller moves only on a detected test-clock rise
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= BSC_TLR;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    // Controller state and instruction decodes shared by the data paths
    assign in_cap_dr = (state == BSC_CAP_DR);
    assign in_sh_dr = (state == BSC_SH_DR);
    assign in_upd_dr = (state == BSC_UPD_DR);
    assign in_cap_ir = (state == BSC_CAP_IR);
    assign in_sh_ir = (state == BSC_SH_IR);
    assign in_upd_ir = (state == BSC_UPD_IR);
    assign op_extest = (ir == BSC_OP_EXTEST);
    assign op_sample = (ir == BSC_OP_SAMPLE);
    assign op_clamp = (ir == BSC_OP_CLAMP);
    assign op_highz = (ir == BSC_OP_HIGHZ);

    // Instruction register: shifted on rise, made current on fall in Update-IR
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ir_sr <= BSC_IR_RESET;
            ir <= BSC_IR_RESET;
        end else if (state == BSC_TLR) begin
            ir <= BSC_IR_RESET;
        end else if (tck_rise && in_cap_ir) begin
            ir_sr <= BSC_IR_CAPTURE;
        end else if (tck_rise && in_sh_ir) begin
            ir_sr <= {jtag_val[2], ir_sr[BSC_IR_W-1:1]};
        end else if (tck_fall && in_upd_ir) begin
            ir <= ir_sr;
        end
    end

    // Only extest and sample route the boundary chain; all else uses bypass
    assign sel_bsr = op_extest || op_sample;

    // Capture and shift act on the rise, update on the fall
    always_comb begin
        ctl.capture = tck_rise && in_cap_dr && sel_bsr;
        ctl.shift = tck_rise && in_sh_dr && sel_bsr;
        ctl.update = tck_fall && in_upd_dr && sel_bsr;
        ctl.drive = op_extest || op_clamp;
        ctl.float_all = op_highz;
    end

    // Bypass stage loads 0 on capture, then carries one TDI bit per rise
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bypass_bit <= 1'b0;
        end else if (tck_rise && in_cap_dr && !sel_bsr) begin
            bypass_bit <= 1'b0;
        end else if (tck_rise && in_sh_dr && !sel_bsr) begin
            bypass_bit <= jtag_val[2];
        end
    end

    // TDO enable is on only while a shift state moves data out
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tdo_oe_o <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_o <= in_sh_dr || in_sh_ir;
        end
    end

    // TDO moves on the fall so it is settled at the next test-clock rise
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tdo_o <= 1'b0;
        end else if (tck_fall && in_sh_ir) begin
            tdo_o <= ir_sr[0];
        end else if (tck_fall && in_sh_dr) begin
            tdo_o <= sel_bsr ? scan[0] : bypass_bit;
        end
    end

    // Group-disable latches at 1 switch their whole group off while extest or clamp drives the pins
    assign dis_lo = upd[BSC_POS_DIS_LO];
    assign dis_ctl = upd[BSC_POS_DIS_CTL];
    assign dis_hi = upd[BSC_POS_DIS_HI];

    // Position 0 is nearest TDO; TDI enters at the top position
    for (genvar i = 0; i < CHAIN_LEN; i++) begin : g_cell
        localparam bsc_kind_e KIND = BSC_MAP_EMPTY[i] ? BSC_KIND_NONE :
                                     BSC_MAP_INPUT[i] ? BSC_KIND_IN :
                                     BSC_MAP_OUTPUT[i] ? BSC_KIND_OUT : BSC_KIND_BIDIR;
        logic scan_in;

        assign scan_in = (i == CHAIN_LEN - 1) ? jtag_val[2] : scan[(i + 1) % CHAIN_LEN];
        assign grp_en[i] = !((BSC_MAP_GRP_LO[i] && dis_lo) ||
                             (BSC_MAP_GRP_CTL[i] && dis_ctl) ||
                             (BSC_MAP_GRP_HI[i] && dis_hi));

        bsc_cell #(
            .KIND(KIND)
        ) u_cell (
            .clk_i(clk_i),
            .arst_n_i(arst_n_i),
            .ctl_i(ctl),
            .scan_i(scan_in),
            .func_out_i(func_out_i[i]),
            .func_oe_i(func_oe_i[i]),
            .pin_in_i(pin_in_i[i]),
            .grp_en_i(grp_en[i]),
            .scan_o(scan[i]),
            .upd_o(upd[i]),
            .pin_out_o(pin_out_o[i]),
            .pin_oe_o(pin_oe_o[i])
        );
    end

endmodule

// file: logic/bsc_pkg.sv
package bsc_pkg;

    localparam int BSC_CHAIN_LEN = 49;
    localparam int BSC_IR_W = 5;

    // Positions of the group output-disable cells
    localparam int BSC_POS_DIS_LO = 19;
    localparam int BSC_POS_DIS_CTL = 26;
    localparam int BSC_POS_DIS_HI = 48;

    // Per-position maps, bit i stands for chain position i
    localparam logic [48:0] BSC_MAP_EMPTY = 49'h0_0000_0810_0000;
    localparam logic [48:0] BSC_MAP_INPUT = 49'h0_0000_0080_2000;
    localparam logic [48:0] BSC_MAP_OUTPUT = 49'h0_0000_0000_0000;
    localparam logic [48:0] BSC_MAP_GRP_LO = 49'h0_0000_006f_9fff;
    localparam logic [48:0] BSC_MAP_GRP_CTL = 49'h0_0000_f700_0000;
    localparam logic [48:0] BSC_MAP_GRP_HI = 49'h1_ffff_0000_0000;

    localparam logic [4:0] BSC_OP_EXTEST = 5'h00;
    localparam logic [4:0] BSC_OP_SAMPLE = 5'h01;
    localparam logic [4:0] BSC_OP_CLAMP = 5'h04;
    localparam logic [4:0] BSC_OP_HIGHZ = 5'h05;
    localparam logic [4:0] BSC_OP_BYPASS = 5'h1f;
    localparam logic [4:0] BSC_IR_CAPTURE = 5'h01;
    localparam logic [4:0] BSC_IR_RESET = 5'h1f;

    localparam logic [2:0] BSC_SYNC_RESET = 3'h0;
    localparam logic BSC_CELL_RESET = 1'b0;

    typedef enum logic [1:0] {
        BSC_KIND_NONE,
        BSC_KIND_IN,
        BSC_KIND_OUT,
        BSC_KIND_BIDIR
    } bsc_kind_e;

    typedef enum logic [3:0] {
        BSC_TLR, BSC_RTI, BSC_SEL_DR, BSC_CAP_DR, BSC_SH_DR, BSC_EX1_DR, BSC_PA_DR,
        BSC_EX2_DR, BSC_UPD_DR, BSC_SEL_IR, BSC_CAP_IR, BSC_SH_IR, BSC_EX1_IR,
        BSC_PA_IR, BSC_EX2_IR, BSC_UPD_IR
    } bsc_tap_e;

    // One-cycle strobes and mode levels shared by every cell
    typedef struct packed {
        logic capture;
        logic shift;
        logic update;
        logic drive;
        logic float_all;
    } bsc_ctl_s;

endpackage

// file: verification/bsc_chain_checker.sv
module bsc_chain_checker
    import bsc_pkg::*;
#(
    parameter int CHAIN_LEN = BSC_CHAIN_LEN
) (
    input wire logic clk_i, // Clock
    input wire logic arst_n_i, // Reset
    input wire logic tck_i, // Test clock
    input wire logic tdo_o, // Test data out
    input wire logic tdo_oe_o, // TDO enable
    input wire logic [CHAIN_LEN-1:0] func_out_i, // Functional values
    input wire logic [CHAIN_LEN-1:0] func_oe_i, // Functional enables
    input wire logic [CHAIN_LEN-1:0] pin_out_o, // Pin values
    input wire logic [CHAIN_LEN-1:0] pin_oe_o // Pin enables
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [CHAIN_LEN-1:0] NO_DRV = CHAIN_LEN'(BSC_MAP_EMPTY | BSC_MAP_INPUT);
    logic tck_q;
    logic [3:0] calm;
    logic [1:0] age;
    logic seen;
    wire quiet = calm >= 4'ha;
    wire fresh = age == 2'h3 && !seen;
    // Cycles since the test clock last moved
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tck_q <= 1'b0;
            calm <= 4'h0;
        end else begin
            tck_q <= tck_i;
            calm <= (tck_i != tck_q) ? 4'h0 : (calm == 4'hf) ? calm : calm + 4'h1;
        end
    end
    // Settled after reset with no test clock seen yet
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            age <= 2'h0;
            seen <= 1'b0;
        end else begin
            age <= (age == 2'h3) ? age : age + 2'h1;
            seen <= seen | tck_i;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence tdo_steady;
        ##2 ($stable(tdo_o) && $stable(tdo_oe_o))[*2];
    endsequence
    reset_clear_a: assert property ($rose(arst_n_i) |-> !tdo_oe_o && pin_oe_o == '0)
        else $error("outputs not cleared");
    no_drive_oe_a: assert property ((pin_oe_o & NO_DRV) == '0)
        else $error("enable on input or empty cell");
    no_drive_out_a: assert property ((pin_out_o & NO_DRV) == '0)
        else $error("value on input or empty cell");
    tdo_hold_a: assert property ($rose(tck_i) |-> tdo_steady)
        else $error("tdo moved after test clock rise");
    tdo_quiet_a: assert property (quiet |=> $stable(tdo_o) && $stable(tdo_oe_o))
        else $error("tdo moved with test clock idle");
    oe_quiet_a: assert property (quiet && $stable(func_oe_i) |=> $stable(pin_oe_o))
        else $error("pin enable moved without cause");
    out_quiet_a: assert property (quiet && $stable(func_out_i) |=> $stable(pin_out_o))
        else $error("pin value moved without cause");
    func_follow_a: assert property (fresh |-> pin_oe_o == ($past(func_oe_i) & ~NO_DRV)
        && pin_out_o == ($past(func_out_i) & ~NO_DRV)) else $error("pins not functional");
endmodule
bind bsc_chain bsc_chain_checker #(.CHAIN_LEN(CHAIN_LEN)) u_chk (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .tck_i(tck_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
    .func_out_i(func_out_i), .func_oe_i(func_oe_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));

// file: verification/bsc_tester.sv
module bsc_tester (
    input wire logic clk_i, // Pacing clock
    output logic tck_o, // Test clock
    output logic tms_o, // Mode select
    output logic tdi_o, // Data in
    input wire logic tdo_i // Data out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end
    // One 320 ns period; tdo read just before the rise
    task automatic tick(input logic ms, input logic di, output logic dout);
        tms_o = ms;
        tdi_o = di;
        repeat (4) @(posedge clk_i);
        #1;
        dout = tdo_i;
        tck_o = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        tck_o = 1'b0;
    endtask
    task automatic scan(input logic ir, input int n, input logic [48:0] din,
        output logic [48:0] dout);
        logic b;
        dout = '0;
        tick(1'b1, 1'b0, b);
        if (ir) begin
            tick(1'b1, 1'b0, b);
        end
        tick(1'b0, 1'b0, b);
        tick(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], dout[i]);
        end
        tick(1'b1, 1'b0, b);
        tick(1'b0, 1'b0, b);
        // Idle data line must not keep the last bit
        @(posedge clk_i);
        #1;
        tdi_o = ~tdi_o;
        @(posedge clk_i);
        #1;
    endtask
    task automatic tlr();
        logic b;
        repeat (5) tick(1'b1, 1'b0, b);
        tick(1'b0, 1'b0, b);
    endtask
endmodule

// file: verification/testbench.sv
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("FAIL %0t: got %h expected %h", $time, a, b); end end
module testbench
    import bsc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [48:0] NO_DRV = BSC_MAP_EMPTY | BSC_MAP_INPUT;
    localparam logic [4:0] OPS [7] = '{BSC_OP_SAMPLE, BSC_OP_EXTEST, BSC_OP_EXTEST,
        BSC_OP_CLAMP, BSC_OP_HIGHZ, 5'h0a, BSC_OP_BYPASS};
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic tck, tms, tdi, tdo, tdo_oe;
    logic [48:0] func_out = '0, func_oe = '0, pin_in = '0, lat = '0;
    logic [48:0] pin_out, pin_oe, d, r, r_got, r_exp;
    logic [48:0] exp_q[$], got_q[$];
    logic drv, hz, bnd;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    int oe_hi = 0;
    always #20 clk_i = ~clk_i;
    bsc_chain dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .tdo_o(tdo), .tdo_oe_o(tdo_oe), .func_out_i(func_out), .func_oe_i(func_oe),
        .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe));
    bsc_tester tst (.clk_i(clk_i), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
    task automatic report_and_stop();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic note(input logic [48:0] e, input logic [48:0] g);
        exp_q.push_back(e);
        got_q.push_back(g);
    endtask
    // Test-clock rises that find TDO enabled; only the shifted bits should
    always @(posedge tck) oe_hi = oe_hi + int'(tdo_oe);
    task automatic run_scan(input logic ir, input int n, input logic [48:0] din);
        oe_hi = 0;
        tst.scan(ir, n, din, r);
        note(49'(n), 49'(oe_hi));
    endtask
    function automatic logic [48:0] grp_oe(input logic [48:0] u);
        return ({49{~u[19]}} & BSC_MAP_GRP_LO) | ({49{~u[26]}} & BSC_MAP_GRP_CTL)
            | ({49{~u[48]}} & BSC_MAP_GRP_HI) | 49'h0_0000_0000_4000;
    endfunction
    task automatic check_pins(input logic dr, input logic z);
        repeat (3) @(negedge clk_i);
        if (!z) begin
            note((dr ? lat : func_out) & ~NO_DRV, pin_out);
        end
        note(z ? '0 : dr ? grp_oe(lat) : func_oe & ~NO_DRV, pin_oe);
    endtask
    task automatic randomise();
        @(posedge clk_i);
        #1;
        func_out = 49'({$urandom, $urandom});
        func_oe = 49'({$urandom, $urandom});
        pin_in = 49'({$urandom, $urandom});
        d = 49'({$urandom, $urandom});
        // Flip every group-disable bit on each boundary update
        d[19] = ~lat[19];
        d[26] = ~lat[26];
        d[48] = ~lat[48];
    endtask
    initial forever begin
        wait (got_q.size() != 0);
        r_got = got_q.pop_front();
        r_exp = exp_q.pop_front();
        `CHK(r_got, r_exp)
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(29));
        repeat (10) @(posedge clk_i);
        #1;
        arst_n_i = 1'b1;
        randomise();
        check_pins(1'b0, 1'b0);
        tst.tlr();
        run_scan(1'b0, 49, d);
        note({d[47:0], 1'b0}, r);
        foreach (OPS[k]) begin
            drv = OPS[k] == BSC_OP_EXTEST || OPS[k] == BSC_OP_CLAMP;
            hz = OPS[k] == BSC_OP_HIGHZ;
            bnd = OPS[k] == BSC_OP_EXTEST || OPS[k] == BSC_OP_SAMPLE;
            randomise();
            run_scan(1'b1, 5, 49'(OPS[k]));
            note(49'(BSC_IR_CAPTURE), r);
            check_pins(drv, hz);
            run_scan(1'b0, 49, d);
            note(bnd ? pin_in & ~BSC_MAP_EMPTY : {d[47:0], 1'b0}, r);
            lat = bnd ? d : lat;
            check_pins(drv, hz);
        end
        run_scan(1'b1, 5, 49'(BSC_OP_EXTEST));
        tst.tlr();
        check_pins(1'b0, 1'b0);
        repeat (4) @(posedge clk_i);
        report_and_stop();
    end
endmodule
